/* hw/network_core_register_bank.sv */
// Purpose: host-visible registers of the token-passing network core
// Assumes: sequencer events on core_clk; line input asynchronous
// Notes:   read data returns one cycle after the read strobe
//
// Overview of operation
// R1: probe address register, 8-bit read/write, cleared by hardware reset only.
// R2: probe-match flag set when a response to the probe address is seen.
// R3: next station in token order is not probed; successor register shows it.
// R4: sequencer stays asleep while the own station address is zero.
// R5: non-zero address wakes core; joining waits for transmit-join enable.
// R6: own station address register, 8-bit read/write, hardware reset only.
// R7: read-only successor address, updated by the sequencer on ring changes.
// R8: each successor update raises a flag cleared by reading that register.
// R9: successor address clears on hardware and software reset.
// R10: status resets to 1xx1_0001 on hardware or software reset.
// R11: diagnostic read clears all flags but excess-nak and new-successor.
// R12: excess-nak flag cleared only by the flag-clearing command.
// R13: each command write starts that command; only listed codes allowed.
// R14: upper pointer written first; lower write loads the full pointer.
// R15: configuration register resets to 0001_1000 on hardware reset only.
// R16: setup register controls rate, arbitration, receive-all, driver, timeouts.
// R17: setup can slow the line rate and halve arbitration speed.
// R18: receive-inhibit bit set until a receive-arm command clears it.
// R19: power-on bit set by resets or writing zero station address.
// R20: idle-timeout bit set after 82 us of quiet line input.
// R21: transmit-acknowledged bit set on ack, cleared by next launch.
// R22: transmitter-free bit set on completion, cleared when launch meets token.
// R23: a flag event in the clearing read cycle stays set.
// R24: sub-address field decoded on every shared-offset access, no wait.
`timescale 1ns/1ps
`default_nettype none
module network_core_register_bank
    import netcore_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = LINE_IDLE_CYCLES
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire netcore_pkg::reg_req_t     bus_req,
    output logic [7:0]                     rd_data,
    input  wire netcore_pkg::seq_events_t  seq_evt,
    input  wire logic                      line_receive_input,
    output logic                           sequencer_awake,
    output logic                           transmit_join_enable,
    output logic                           cmd_strobe,
    output logic [7:0]                     cmd_code,
    output logic                           pointer_load,
    output logic [15:0]                    ram_pointer,
    output logic [7:0]                     line_speed_setup,
    output logic [7:0]                     core_mode_configuration,
    output logic [7:0]                     probe_station_address,
    output logic [7:0]                     own_station_address,
    output logic                           core_irq
);
    import netcore_pkg::*;

    if (IDLE_CYCLES < 1 || IDLE_CYCLES >= (1 << IDLE_CNT_W)) begin : g_idle_check
        $error("IDLE_CYCLES out of range");
    end

    // decode helper for read/write selects
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    logic [7:0] probe_reg;
    logic [7:0] own_reg;
    logic [7:0] succ_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] diag_reg;
    logic [7:0] diag_next;
    logic [7:0] mask_reg;
    logic [7:0] cfg_reg;
    logic [7:0] setup_reg;
    logic [7:0] ptr_hi_reg;
    logic [7:0] ptr_lo_reg;
    logic [15:0] ptr_reg;
    logic [7:0] rd_reg;
    logic [7:0] rd_next;
    logic       irq_reg;
    logic       cmd_strobe_reg;
    logic [7:0] cmd_code_reg;
    logic       ptr_load_reg;
    logic       awake_reg;
    logic       join_reg;
    logic       launch_pending_reg;
    logic       rx_meta_reg;
    logic       rx_sync_reg;
    logic [IDLE_CNT_W-1:0] idle_cnt_reg;
    logic       idle_armed_reg;

    // bus decode
    wire        soft_rst    = reset | cfg_reg[CFG_SOFT_RESET];
    wire [1:0]  sub_sel     = cfg_reg[1:0];
    wire        wr          = bus_req.wr_en;
    wire        rd          = bus_req.rd_en;
    wire [3:0]  a           = bus_req.addr;
    wire [7:0]  wd          = bus_req.wdata;
    wire        sub_hit     = hit(a, OFF_SUBREG);
    // R24: sub-address decode
    wire        sel_probe   = sub_hit & (sub_sel == SUB_PROBE);
    wire        sel_own     = sub_hit & (sub_sel == SUB_OWN);
    wire        sel_setup   = sub_hit & (sub_sel == SUB_SETUP);
    wire        sel_succ    = sub_hit & (sub_sel == SUB_SUCCESSOR);
    wire        wr_mask     = wr & hit(a, OFF_STATUS_MASK);
    wire        wr_cmd      = wr & hit(a, OFF_DIAG_CMD);
    wire        wr_ptr_hi   = wr & hit(a, OFF_PTR_UPPER);
    wire        wr_ptr_lo   = wr & hit(a, OFF_PTR_LOWER);
    wire        wr_cfg      = wr & hit(a, OFF_CONFIG);
    wire        wr_probe    = wr & sel_probe;
    wire        wr_own      = wr & sel_own;
    wire        wr_setup    = wr & sel_setup;
    wire        rd_diag     = rd & hit(a, OFF_DIAG_CMD);
    wire        rd_succ     = rd & sel_succ;

    // command decode
    wire        cmd_launch  = wr_cmd & (wd[2:0] == CMD_OP_LAUNCH);
    wire        cmd_rx_arm  = wr_cmd & (wd[2:0] == CMD_OP_RX_ARM);
    wire        cmd_tx_off  = wr_cmd & (wd == CMD_TX_DISABLE);
    wire        cmd_clr     = wr_cmd & (wd == CMD_CLR_FLAGS);
    wire        own_zero_wr = wr_own & (wd == RST_ZERO);
    wire        idle_expire;
    wire        ta_clear    = launch_pending_reg & seq_evt.token_held;

    // read mux
    always_comb begin
        rd_next = RST_ZERO;
        case (a)
            OFF_STATUS_MASK: rd_next = status_reg;
            OFF_DIAG_CMD:    rd_next = diag_reg;
            OFF_PTR_UPPER:   rd_next = ptr_hi_reg;
            OFF_PTR_LOWER:   rd_next = ptr_lo_reg;
            OFF_CONFIG:      rd_next = cfg_reg;
            OFF_SUBREG: begin
                case (sub_sel)
                    SUB_PROBE: rd_next = probe_reg;
                    SUB_OWN:   rd_next = own_reg;
                    SUB_SETUP: rd_next = setup_reg;
                    default:   rd_next = succ_reg;
                endcase
            end
            default:         rd_next = RST_ZERO;
        endcase
    end

    // status next value; sets win over clears
    always_comb begin
        status_next = status_reg;
        // R18: receive inhibit
        if (cmd_rx_arm) begin
            status_next[ST_RX_INHIBIT] = 1'b0;
        end
        if (seq_evt.rx_stored) begin
            status_next[ST_RX_INHIBIT] = 1'b1;
        end
        // R19: power-on flag
        if (cmd_clr) begin
            status_next[ST_POR] = 1'b0;
        end
        if (own_zero_wr) begin
            status_next[ST_POR] = 1'b1;
        end
        // R20: idle timeout flag
        if (cmd_clr) begin
            status_next[ST_IDLE_TMO] = 1'b0;
        end
        if (idle_expire) begin
            status_next[ST_IDLE_TMO] = 1'b1;
        end
        // R21: acknowledged flag
        if (cmd_launch) begin
            status_next[ST_TX_ACK] = 1'b0;
        end
        if (seq_evt.tx_acked) begin
            status_next[ST_TX_ACK] = 1'b1;
        end
        // R22: transmitter free flag
        if (ta_clear) begin
            status_next[ST_TX_FREE] = 1'b0;
        end
        if (seq_evt.tx_done || cmd_tx_off) begin
            status_next[ST_TX_FREE] = 1'b1;
        end
        status_next[6:5] = 2'b00;
        status_next[3]   = 1'b0;
    end

    // diagnostic next value
    always_comb begin
        diag_next = diag_reg;
        // R11: clear on read
        if (rd_diag) begin
            diag_next = diag_reg & ~DIAG_READ_CLEAR;
        end
        // R12: excess nak cleared by command only
        if (cmd_clr) begin
            diag_next[DG_EXC_NAK] = 1'b0;
        end
        // R8: new successor cleared by successor read
        if (rd_succ) begin
            diag_next[DG_NEW_SUCC] = 1'b0;
        end
        // R23: events win over the read
        // R2: probe match
        if (seq_evt.probe_match) begin
            diag_next[DG_PROBE] = 1'b1;
        end
        if (seq_evt.successor_update) begin
            diag_next[DG_NEW_SUCC] = 1'b1;
        end
        if (seq_evt.my_line_idle_timeout_flag) begin
            diag_next[DG_MY_LINE_IDLE_TIMEOUT_FLAG] = 1'b1;
        end
        if (seq_evt.duplicate) begin
            diag_next[DG_DUP] = 1'b1;
        end
        if (seq_evt.token_seen) begin
            diag_next[DG_TOKEN] = 1'b1;
        end
        if (seq_evt.excess_nak) begin
            diag_next[DG_EXC_NAK] = 1'b1;
        end
        if (rx_sync_reg) begin
            diag_next[DG_RX_ACT] = 1'b1;
        end
        diag_next[0] = 1'b0;
    end

    // line input synchroniser
    always_ff @(posedge core_clk) begin
        rx_meta_reg <= line_receive_input;
        rx_sync_reg <= rx_meta_reg;
    end

    // R20: line idle timer
    assign idle_expire = idle_armed_reg & ~rx_sync_reg
                       & (idle_cnt_reg == IDLE_CNT_W'(IDLE_CYCLES - 1));
    always_ff @(posedge core_clk) begin
        if (soft_rst || rx_sync_reg) begin
            idle_cnt_reg   <= '0;
            idle_armed_reg <= 1'b1;
        end else if (idle_expire) begin
            idle_cnt_reg   <= '0;
            idle_armed_reg <= 1'b0;
        end else if (idle_armed_reg) begin
            idle_cnt_reg   <= idle_cnt_reg + 1'b1;
        end
    end

    // hardware-reset-only registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            // R1: probe address
            probe_reg  <= RST_ZERO;
            // R6: own address
            own_reg    <= RST_ZERO;
            // R15: configuration
            cfg_reg    <= RST_CONFIG;
            // R16: setup
            setup_reg  <= RST_ZERO;
            ptr_hi_reg <= RST_ZERO;
            ptr_lo_reg <= RST_ZERO;
            ptr_reg    <= '0;
            mask_reg   <= RST_ZERO;
        end else begin
            if (wr_probe) begin
                probe_reg <= wd;
            end
            if (wr_own) begin
                own_reg <= wd;
            end
            if (wr_cfg) begin
                cfg_reg <= wd;
            end
            // R17: rate and arbitration bits held here
            if (wr_setup) begin
                setup_reg <= wd;
            end
            if (wr_mask) begin
                mask_reg <= wd;
            end
            if (wr_ptr_hi) begin
                ptr_hi_reg <= wd;
            end
            // R14: lower write loads pointer
            if (wr_ptr_lo) begin
                ptr_lo_reg <= wd;
                ptr_reg    <= {ptr_hi_reg, wd};
            end
        end
    end

    // registers cleared by either reset
    always_ff @(posedge core_clk) begin
        if (soft_rst) begin
            // R9: successor clears
            succ_reg           <= RST_ZERO;
            // R10: status reset value
            status_reg         <= RST_STATUS;
            diag_reg           <= RST_DIAG;
            launch_pending_reg <= 1'b0;
        end else begin
            // R7: sequencer updates successor
            // R3: successor shown here
            if (seq_evt.successor_update) begin
                succ_reg <= seq_evt.successor_value;
            end
            status_reg <= status_next;
            diag_reg   <= diag_next;
            if (cmd_launch) begin
                launch_pending_reg <= 1'b1;
            end else if (ta_clear) begin
                launch_pending_reg <= 1'b0;
            end
        end
    end

    // outputs and strobes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_reg         <= RST_ZERO;
            cmd_strobe_reg <= 1'b0;
            cmd_code_reg   <= RST_ZERO;
            ptr_load_reg   <= 1'b0;
            awake_reg      <= 1'b0;
            join_reg       <= 1'b0;
            irq_reg        <= 1'b0;
        end else begin
            if (rd) begin
                rd_reg <= rd_next;
            end
            // R13: every command write starts it
            cmd_strobe_reg <= wr_cmd;
            if (wr_cmd) begin
                cmd_code_reg <= wd;
            end
            ptr_load_reg <= wr_ptr_lo;
            // R4: asleep while address zero
            awake_reg    <= (own_reg != RST_ZERO) & ~cfg_reg[CFG_SOFT_RESET];
            // R5: join needs enable too
            join_reg     <= (own_reg != RST_ZERO) & ~cfg_reg[CFG_SOFT_RESET]
                          & cfg_reg[CFG_TX_JOIN];
            irq_reg      <= |({status_reg[7], 2'b00, 2'b00, status_reg[2], 1'b0,
                               status_reg[0]} & mask_reg)
                          | (diag_reg[DG_EXC_NAK] & mask_reg[3])
                          | (diag_reg[DG_NEW_SUCC] & mask_reg[1]);
        end
    end

    assign rd_data                 = rd_reg;
    assign cmd_strobe              = cmd_strobe_reg;
    assign cmd_code                = cmd_code_reg;
    assign pointer_load            = ptr_load_reg;
    assign ram_pointer             = ptr_reg;
    assign line_speed_setup        = setup_reg;
    assign core_mode_configuration = cfg_reg;
    assign probe_station_address   = probe_reg;
    assign own_station_address     = own_reg;
    assign sequencer_awake         = awake_reg;
    assign transmit_join_enable    = join_reg;
    assign core_irq                = irq_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_probe_sets_flag: assert property ( // R2
        seq_evt.probe_match && !soft_rst |=> diag_reg[DG_PROBE])
        else $error("probe match lost");
    chk_sleep_zero_addr: assert property ( // R4
        own_reg == RST_ZERO |=> !sequencer_awake && !transmit_join_enable)
        else $error("awake with zero address");
    chk_join_needs_en: assert property ( // R5
        transmit_join_enable |-> $past(cfg_reg[CFG_TX_JOIN]))
        else $error("joined without enable");
    chk_succ_update: assert property ( // R8
        seq_evt.successor_update && !soft_rst
        |=> diag_reg[DG_NEW_SUCC] && succ_reg == $past(seq_evt.successor_value))
        else $error("successor update lost");
    chk_status_reset: assert property ( // R10
        cfg_reg[CFG_SOFT_RESET] |=> status_reg == RST_STATUS)
        else $error("status reset value wrong");
    chk_diag_read_clr: assert property ( // R11
        rd_diag && !soft_rst && !cmd_clr && seq_evt == '0 && !rx_sync_reg
        |=> (diag_reg & DIAG_READ_CLEAR) == 8'h00
            && diag_reg[DG_EXC_NAK] == $past(diag_reg[DG_EXC_NAK]))
        else $error("diagnostic read clear wrong");
    chk_excess_negative_ack_flag_cmd_only: assert property ( // R12
        diag_reg[DG_EXC_NAK] && !cmd_clr && !soft_rst |=> diag_reg[DG_EXC_NAK])
        else $error("excess nak cleared early");
    chk_cmd_strobe: assert property ( // R13
        wr_cmd |=> cmd_strobe && cmd_code == $past(wd))
        else $error("command not issued");
    chk_ptr_load: assert property ( // R14
        wr_ptr_hi ##1 wr_ptr_lo |=> ram_pointer == {$past(wd, 2), $past(wd)})
        else $error("pointer not loaded");
    chk_zero_addr_por: assert property ( // R19
        own_zero_wr && !soft_rst |=> status_reg[ST_POR])
        else $error("power-on flag not set");
    chk_ta_on_done: assert property ( // R22
        (seq_evt.tx_done || cmd_tx_off) && !soft_rst |=> status_reg[ST_TX_FREE])
        else $error("transmitter free not set");

    cov_diag_read: cover property (rd_diag ##1 rd);
    cov_idle_expire: cover property (idle_expire);
    cov_launch_token: cover property (cmd_launch ##[1:20] ta_clear);
endmodule
`default_nettype wire

/* hw/netcore_pkg.sv */
// Purpose: shared constants and types for the network core register bank
// Assumes: 8-bit register bus on the core clock, 50 MHz
// Notes:   command codes and sub-address codes are local choices
package netcore_pkg;
    // register offsets
    localparam logic [3:0] OFF_STATUS_MASK = 4'h0;
    localparam logic [3:0] OFF_DIAG_CMD    = 4'h1;
    localparam logic [3:0] OFF_PTR_UPPER   = 4'h2;
    localparam logic [3:0] OFF_PTR_LOWER   = 4'h3;
    localparam logic [3:0] OFF_CONFIG      = 4'h6;
    localparam logic [3:0] OFF_SUBREG      = 4'h7;
    // sub-address codes in configuration bits 1:0
    localparam logic [1:0] SUB_PROBE     = 2'h0;
    localparam logic [1:0] SUB_OWN       = 2'h1;
    localparam logic [1:0] SUB_SETUP     = 2'h2;
    localparam logic [1:0] SUB_SUCCESSOR = 2'h3;
    // configuration field positions
    localparam int CFG_SOFT_RESET = 7;
    localparam int CFG_TX_JOIN    = 5;
    // status field positions
    localparam int ST_RX_INHIBIT = 7;
    localparam int ST_POR        = 4;
    localparam int ST_IDLE_TMO   = 2;
    localparam int ST_TX_ACK     = 1;
    localparam int ST_TX_FREE    = 0;
    // diagnostic field positions
    localparam int DG_MY_LINE_IDLE_TIMEOUT_FLAG   = 7;
    localparam int DG_DUP        = 6;
    localparam int DG_RX_ACT     = 5;
    localparam int DG_TOKEN      = 4;
    localparam int DG_EXC_NAK    = 3;
    localparam int DG_PROBE      = 2;
    localparam int DG_NEW_SUCC   = 1;
    // reset values
    localparam logic [7:0] RST_STATUS = 8'h91;
    localparam logic [7:0] RST_DIAG   = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h18;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    // diagnostic bits cleared by a read
    localparam logic [7:0] DIAG_READ_CLEAR = 8'hf4;
    // command codes
    localparam logic [7:0] CMD_TX_DISABLE = 8'h01;
    localparam logic [7:0] CMD_CLR_FLAGS  = 8'h0e;
    localparam logic [2:0] CMD_OP_LAUNCH  = 3'h3;
    localparam logic [2:0] CMD_OP_RX_ARM  = 3'h4;
    // timing
    localparam int CLK_PERIOD_NS     = 20;
    localparam int LINE_IDLE_NS      = 82000;
    localparam int LINE_IDLE_CYCLES  = LINE_IDLE_NS / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W        = 13;

    // events reported by the protocol sequencer, one-cycle pulses
    typedef struct packed {
        logic       probe_match;
        logic       successor_update;
        logic [7:0] successor_value;
        logic       my_line_idle_timeout_flag;
        logic       duplicate;
        logic       token_seen;
        logic       excess_nak;
        logic       rx_stored;
        logic       tx_done;
        logic       tx_acked;
        logic       token_held;
    } seq_events_t;

    // register bus request
    typedef struct packed {
        logic       rd_en;
        logic       wr_en;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

/* verification/seq_model.sv */
// Purpose: sequencer event source on the far side of the register bank
// Assumes: one event per kick code, same clock as the bank
// Notes:   every event is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module seq_model
    import netcore_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic [2:0]            kick,
    input  wire logic [7:0]            value,
    output var netcore_pkg::seq_events_t seq_evt
);
    always_ff @(posedge core_clk) begin
        seq_evt <= '0;
        seq_evt.probe_match      <= (kick == 3'h1);
        seq_evt.successor_update <= (kick == 3'h2);
        seq_evt.successor_value  <= value;
        seq_evt.excess_nak       <= (kick == 3'h3);
        seq_evt.rx_stored        <= (kick == 3'h4);
        seq_evt.tx_acked         <= (kick == 3'h5);
        seq_evt.token_held       <= (kick == 3'h6);
        seq_evt.tx_done          <= (kick == 3'h7);
    end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Purpose: self-checking bench for the network core register bank
// Assumes: short idle count of 8 cycles
// Notes:   register bus driven on rising edges
`timescale 1ns/1ps
`default_nettype none
module tb;
    import netcore_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    reg_req_t    bus_req  = '0;
    logic        line_receive_input = 1'b0;
    logic [2:0]  kick     = '0;
    logic [7:0]  value    = '0;
    seq_events_t seq_evt;
    logic [7:0]  rd_data;
    logic        awake;
    logic        join_en;
    logic [15:0] ram_pointer;
    logic [7:0]  probe_q;
    logic [7:0]  own_q;
    logic [7:0]  setup_q;
    logic [7:0]  cfg_q;
    logic [7:0]  ccode;
    logic        cstb;
    logic        pload;
    logic        irq;
    logic [7:0]  d;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cyc        = 0;

    always #10 core_clk = ~core_clk;

    seq_model seq_u (.core_clk(core_clk), .kick(kick), .value(value), .seq_evt(seq_evt));

    network_core_register_bank #(.IDLE_CYCLES(8)) dut_u (
        .core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
        .seq_evt(seq_evt), .line_receive_input(line_receive_input),
        .sequencer_awake(awake), .transmit_join_enable(join_en), .cmd_strobe(cstb),
        .cmd_code(ccode), .pointer_load(pload), .ram_pointer(ram_pointer),
        .line_speed_setup(setup_q), .core_mode_configuration(cfg_q),
        .probe_station_address(probe_q), .own_station_address(own_q), .core_irq(irq)
    );

    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus_req.wr_en <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= v;
        @(posedge core_clk);
        bus_req.wr_en <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req.rd_en <= 1'b1;
        bus_req.addr  <= a;
        @(posedge core_clk);
        bus_req.rd_en <= 1'b0;
        #1 d = rd_data;
        chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic fire(input logic [2:0] k, input logic [7:0] v);
        @(posedge core_clk);
        kick  <= k;
        value <= v;
        @(posedge core_clk);
        kick  <= 3'h0;
        value <= ~v;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic t_reset;
        rdc(OFF_STATUS_MASK, RST_STATUS);
        rdc(OFF_CONFIG, RST_CONFIG);
        rdc(OFF_DIAG_CMD, RST_DIAG);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CONFIG, 8'h18 | 8'(i));
            rdc(OFF_SUBREG, RST_ZERO);
        end
        $display("reset values done");
    endtask

    task automatic t_subaddr;
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CONFIG, 8'h18 | 8'(i));
            wr(OFF_SUBREG, 8'ha0 + 8'(i));
            rdc(OFF_SUBREG, (i == 3) ? 8'h00 : 8'ha0 + 8'(i));
        end
        chk({8'h00, probe_q}, 16'h00a0);
        chk({8'h00, own_q}, 16'h00a1);
        chk({8'h00, setup_q}, 16'h00a2);
        chk({8'h00, cfg_q}, 16'h001b);
        $display("sub-address done");
    endtask

    task automatic t_successor;
        fire(3'h2, 8'h5a);
        rdc(OFF_DIAG_CMD, 8'h02);
        rdc(OFF_DIAG_CMD, 8'h02);
        rdc(OFF_SUBREG, 8'h5a);
        rdc(OFF_DIAG_CMD, 8'h00);
        $display("successor done");
    endtask

    task automatic t_diag;
        fire(3'h1, 8'h00);
        fire(3'h3, 8'h00);
        rdc(OFF_DIAG_CMD, 8'h0c);
        rdc(OFF_DIAG_CMD, 8'h08);
        wr(OFF_DIAG_CMD, CMD_CLR_FLAGS);
        @(negedge core_clk);
        chk({7'h0, cstb, ccode}, {8'h01, CMD_CLR_FLAGS});
        rdc(OFF_DIAG_CMD, 8'h00);
        $display("diagnostic done");
    endtask

    task automatic t_status;
        rdc(OFF_STATUS_MASK, 8'h81);
        wr(OFF_DIAG_CMD, {5'h00, CMD_OP_RX_ARM});
        rdc(OFF_STATUS_MASK, 8'h01);
        @(posedge core_clk);
        line_receive_input <= 1'b1;
        repeat (4) @(posedge core_clk);
        line_receive_input <= 1'b0;
        repeat (14) @(posedge core_clk);
        rdc(OFF_STATUS_MASK, 8'h05);
        $display("status done");
    endtask

    task automatic t_wake;
        wr(OFF_CONFIG, 8'h19);
        wr(OFF_SUBREG, 8'h00);
        repeat (3) @(negedge core_clk);
        chk({15'h0, awake}, 16'h0000);
        wr(OFF_SUBREG, 8'h05);
        repeat (3) @(negedge core_clk);
        chk({14'h0, awake, join_en}, 16'h0002);
        wr(OFF_CONFIG, 8'h39);
        repeat (3) @(negedge core_clk);
        chk({15'h0, join_en}, 16'h0001);
        wr(OFF_SUBREG, 8'h00);
        repeat (2) @(posedge core_clk);
        rdc(OFF_STATUS_MASK, 8'h15);
        chk({8'h00, d & 8'h10}, 16'h0010);
        $display("wake done");
    endtask

    task automatic t_pointer;
        wr(OFF_PTR_UPPER, 8'h12);
        wr(OFF_PTR_LOWER, 8'h34);
        @(negedge core_clk);
        chk({15'h0, pload}, 16'h0001);
        chk(ram_pointer, 16'h1234);
        rdc(OFF_PTR_UPPER, 8'h12);
        $display("pointer done");
    endtask

    task automatic t_launch;
        wr(OFF_DIAG_CMD, {5'h00, CMD_OP_LAUNCH});
        fire(3'h6, 8'h00);
        rdc(OFF_STATUS_MASK, 8'h14);
        fire(3'h5, 8'h00);
        rdc(OFF_STATUS_MASK, 8'h16);
        fire(3'h7, 8'h00);
        rdc(OFF_STATUS_MASK, 8'h17);
        wr(OFF_DIAG_CMD, {5'h00, CMD_OP_LAUNCH});
        rdc(OFF_STATUS_MASK, 8'h15);
        fire(3'h6, 8'h00);
        wr(OFF_DIAG_CMD, CMD_TX_DISABLE);
        rdc(OFF_STATUS_MASK, 8'h15);
        fire(3'h4, 8'h00);
        rdc(OFF_STATUS_MASK, 8'h95);
        wr(OFF_STATUS_MASK, 8'h80);
        repeat (2) @(negedge core_clk);
        chk({15'h0, irq}, 16'h0001);
        wr(OFF_STATUS_MASK, 8'h00);
        repeat (2) @(negedge core_clk);
        chk({15'h0, irq}, 16'h0000);
        $display("launch done");
    endtask

    task automatic t_soft;
        fire(3'h2, 8'h33);
        wr(OFF_CONFIG, 8'h9b);
        rdc(OFF_SUBREG, 8'h00);
        rdc(OFF_STATUS_MASK, RST_STATUS);
        wr(OFF_CONFIG, 8'h18);
        rdc(OFF_SUBREG, 8'ha0);
        $display("soft reset done");
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_subaddr();
        t_successor();
        t_diag();
        t_status();
        t_wake();
        t_pointer();
        t_launch();
        t_soft();
        report_and_stop();
    end
endmodule
`default_nettype wire
